/* File: bench/sesp_core_properties.sv */
`timescale 1ns/1ps
module sesp_core_properties #(
   parameter int unsigned STORE_CYCLES = 400
) (
   input wire logic                         sys_clk,
   input wire logic                         rst,
   input wire logic                         spi_cs_n,
   input wire logic                         spi_sck,
   input wire logic                         spi_mosi,
   input wire logic                         wp_n,
   input wire logic                         mem_busy,
   input wire logic                         spi_miso,
   input wire logic                         spi_miso_oe,
   input wire logic                         mem_write_start,
   input wire logic [sesp_pkg::ADDR_W-1:0]  mem_write_addr,
   input wire logic [7:0]                   protection_status_reg
);
   import sesp_pkg::*;
   logic [7:0] sr;
   logic [1:0] ps;
   assign sr = protection_status_reg;
   assign ps = sr[SB_PS_HI:SB_PS_LO];
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   sequence deselected_s;
      spi_cs_n [*8];
   endsequence
   sequence store_cycle_s;
      sr[SB_BUSY] [*8];
   endsequence
   a_fixed_zero: assert property (sr[6:4] == 3'h0)
      else $error("status bits 6 to 4 not zero");
   a_oe_idle: assert property (deselected_s |-> !spi_miso_oe)
      else $error("miso driven while deselected");
   a_write_deselect: assert property (mem_write_start |-> spi_cs_n && $past(spi_cs_n, 3))
      else $error("write issued while selected");
   a_write_armed: assert property (mem_write_start |-> sr[SB_LATCH] && !sr[SB_BUSY])
      else $error("write issued without latch or while busy");
   a_write_disarms: assert property (mem_write_start |=> !sr[SB_LATCH])
      else $error("latch kept after write");
   a_guard_region: assert property (mem_write_start |-> ps == PS_NONE
      || ps == PS_QUARTER && mem_write_addr < PROT_QUARTER
      || ps == PS_HALF && mem_write_addr < PROT_HALF)
      else $error("write issued into guarded region");
   a_busy_hold: assert property ($rose(sr[SB_BUSY]) |-> store_cycle_s)
      else $error("busy cycle too short");
   a_busy_cause: assert property ($rose(sr[SB_BUSY])
      |-> $past(mem_busy) || $past(mem_busy, 2) || $past(spi_cs_n, 3))
      else $error("busy without cause");
   a_busy_mem: assert property (mem_busy [*3] |-> sr[SB_BUSY])
      else $error("busy flag misses array busy");
   a_nv_at_end: assert property ($changed({sr[SB_LOCK], ps})
      |-> $past(sr[SB_BUSY]) || sr[SB_BUSY])
      else $error("protect bits changed outside store end");
endmodule
bind sesp_core sesp_core_properties #(.STORE_CYCLES(STORE_CYCLES)) sesp_core_properties_inst (
   .sys_clk(sys_clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
   .spi_mosi(spi_mosi), .wp_n(wp_n), .mem_busy(mem_busy), .spi_miso(spi_miso),
   .spi_miso_oe(spi_miso_oe), .mem_write_start(mem_write_start),
   .mem_write_addr(mem_write_addr), .protection_status_reg(protection_status_reg));

/* File: bench/sesp_host.sv */
`timescale 1ns/1ps
module sesp_host (
   output logic       spi_cs_n,
   output logic       spi_sck,
   output logic       spi_mosi,
   input wire logic   spi_miso,
   input wire logic   spi_miso_oe
);
   logic miso_w;
   logic seen_oe;
   // A released line shows the inverse, so a stale bit never reads as a match
   assign miso_w = spi_miso_oe ? spi_miso : ~spi_miso;
   initial begin
      spi_cs_n = 1'b1;
      spi_sck = 1'b0;
      spi_mosi = 1'b0;
      seen_oe = 1'b0;
   end
   task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = 32'h0;
      seen_oe = 1'b0;
      spi_cs_n = 1'b0;
      #100;
      for (int i = n - 1; i >= 0; i--) begin
         spi_mosi = tx[i];
         // Take the bit launched by the previous fall just before this rise
         #1 rx = {rx[30:0], miso_w};
         seen_oe = seen_oe | spi_miso_oe;
         spi_sck = 1'b1;
         #32 spi_sck = 1'b0;
         #31;
      end
      // Deselect after the last rise, before any further one
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      #200;
   endtask
endmodule

/* File: bench/test_spi_eeprom_status_protect.sv */
`timescale 1ns/1ps
module test_spi_eeprom_status_protect;
   import sesp_pkg::*;
   localparam int unsigned STORE_N = 400;
   logic              sys_clk = 1'b0;
   logic              rst = 1'b1;
   logic              wp_n = 1'b1;
   logic              mem_busy = 1'b0;
   logic              spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe, mem_write_start;
   logic [ADDR_W-1:0] mem_write_addr;
   logic [ADDR_W-1:0] wr_addr;
   logic [7:0]        protection_status_reg;
   logic [7:0]        s;
   logic [31:0]       rx;
   int                n_fail = 0;
   int                comparisons = 0;
   int                n_wr = 0;
   always #2.5 sys_clk = ~sys_clk;
   sesp_core #(.STORE_CYCLES(STORE_N)) sesp_core_inst (
      .sys_clk(sys_clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
      .spi_mosi(spi_mosi), .wp_n(wp_n), .mem_busy(mem_busy), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .mem_write_start(mem_write_start),
      .mem_write_addr(mem_write_addr), .protection_status_reg(protection_status_reg));
   sesp_host sesp_host_inst (.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
   // Count accepted writes where the registered pulse has settled
   always @(negedge sys_clk) begin
      if (mem_write_start === 1'b1) begin
         n_wr++;
         wr_addr = mem_write_addr;
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic fetch;
      sesp_host_inst.frame({8'h0, OP_FETCH, 16'h0}, 24, rx);
      check("status repeat", rx[7:0], rx[15:8]);
      s = rx[15:8];
   endtask
   task automatic cmd(input logic [31:0] tx, input int n);
      sesp_host_inst.frame(tx, n, rx);
   endtask
   task automatic settle;
      for (int k = 0; k < 10; k++) begin
         fetch();
         if (s[SB_BUSY] === 1'b0)
            break;
      end
   endtask
   task automatic results;
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic t_power_up;
      fetch();
      check("status", s, 8'h00);
      cmd({8'h0, 8'hFF, OP_FETCH, 8'h0}, 24);
      check("miso drive", sesp_host_inst.seen_oe, 1'b0);
      // Array data lives outside this block, so a read leaves the line released
      cmd({OP_READ, 16'h0000, 8'h00}, 32);
      check("miso drive", sesp_host_inst.seen_oe, 1'b0);
      fetch();
      check("status", s, 8'h00);
      $display("test power_up done");
   endtask
   task automatic t_arm;
      cmd(OP_ARM, 8);
      fetch();
      check("status", s, 8'h02);
      cmd(OP_DISARM, 8);
      fetch();
      check("status", s, 8'h00);
      cmd(OP_ARM, 8);
      cmd({OP_DISARM, 1'b0}, 9);
      fetch();
      check("status", s, 8'h02);
      $display("test arm done");
   endtask
   task automatic t_store;
      cmd(OP_DISARM, 8);
      cmd({OP_STORE, 8'h8C}, 16);
      fetch();
      check("status", s, 8'h00);
      cmd(OP_ARM, 8);
      cmd({OP_STORE, 8'h8C, 1'b1}, 17);
      fetch();
      check("status", s, 8'h02);
      cmd({OP_STORE, 8'hFF}, 16);
      fetch();
      check("status", s, 8'h03);
      settle();
      check("status", s, 8'h8C);
      $display("test store done");
   endtask
   task automatic t_lock;
      @(negedge sys_clk) wp_n = 1'b0;
      cmd(OP_ARM, 8);
      cmd({OP_STORE, 8'h00}, 16);
      fetch();
      check("status", s, 8'h8E);
      cmd({OP_WRITE, 16'h0000, 8'hA5}, 32);
      check("writes", n_wr, 0);
      @(negedge sys_clk) wp_n = 1'b1;
      cmd(OP_ARM, 8);
      cmd({OP_STORE, 8'h04}, 16);
      settle();
      check("status", s, 8'h04);
      $display("test lock done");
   endtask
   task automatic t_write;
      cmd(OP_ARM, 8);
      cmd({OP_WRITE, 16'h17FF, 8'hA5}, 32);
      check("writes", n_wr, 1);
      check("write addr", wr_addr, 13'h17FF);
      fetch();
      check("status", s, 8'h04);
      cmd(OP_ARM, 8);
      cmd({OP_WRITE, 16'h1800, 8'hA5}, 32);
      cmd({OP_WRITE, 16'h0100, 7'h0}, 31);
      check("writes", n_wr, 1);
      @(negedge sys_clk) mem_busy = 1'b1;
      fetch();
      check("status", s, 8'h07);
      check("status reg", protection_status_reg, 8'h07);
      cmd({OP_WRITE, 16'h0100, 8'hA5}, 32);
      check("writes", n_wr, 1);
      @(negedge sys_clk) mem_busy = 1'b0;
      $display("test write done");
   endtask
   task automatic t_half;
      // Latch is still armed from the refused writes before
      cmd({OP_STORE, 8'h08}, 16);
      settle();
      check("status", s, 8'h08);
      cmd(OP_ARM, 8);
      cmd({OP_WRITE, 16'h1000, 8'hA5}, 32);
      check("writes", n_wr, 1);
      cmd({OP_WRITE, 16'h0FFF, 8'h5A}, 32);
      check("writes", n_wr, 2);
      check("write addr", wr_addr, 13'h0FFF);
      check("status reg", protection_status_reg, 8'h08);
      $display("test half done");
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk) rst = 1'b0;
      repeat (10) @(negedge sys_clk);
      t_power_up();
      t_arm();
      t_store();
      t_lock();
      t_write();
      t_half();
      results();
   end
   initial begin
      #400000;
      n_fail++;
      $display("watchdog expired");
      results();
   end
endmodule

/* File: logic/sesp_core.sv */
`timescale 1ns/1ps
module sesp_core #(
   parameter int unsigned STORE_CYCLES = sesp_pkg::STORE_CYCLES_DEF
) (
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   input  wire logic                        spi_cs_n,
   input  wire logic                        spi_sck,
   input  wire logic                        spi_mosi,
   input  wire logic                        wp_n,
   input  wire logic                        mem_busy,
   output logic                             spi_miso,
   output logic                             spi_miso_oe,
   output logic                             mem_write_start,
   output logic [sesp_pkg::ADDR_W-1:0]      mem_write_addr,
   output logic [7:0]                       protection_status_reg
);
   import sesp_pkg::*;

   // Pin synchronisers: three stages, a level counts once stages two and three agree
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic [3:0] pin_s3;
   logic [3:0] pin_lvl;
   logic [3:0] pin_lvl_d;
   logic [3:0] next_pin_lvl;

   always_comb begin
      next_pin_lvl = (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_lvl);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_s1 <= PIN_RST;
         pin_s2 <= PIN_RST;
         pin_s3 <= PIN_RST;
         pin_lvl <= PIN_RST;
         pin_lvl_d <= PIN_RST;
      end else begin
         pin_s1 <= {spi_cs_n, spi_sck, spi_mosi, wp_n};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_lvl <= next_pin_lvl;
         pin_lvl_d <= pin_lvl;
      end
   end

   // Select level resets low, so a pin held low from power-up never selects:
   // the device needs a real falling edge first.
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic mosi_bit;
   logic wp_high;
   assign cs_fall = ~pin_lvl[PIN_CS] & pin_lvl_d[PIN_CS];
   assign cs_rise = pin_lvl[PIN_CS] & ~pin_lvl_d[PIN_CS];
   assign sck_rise = pin_lvl[PIN_SCK] & ~pin_lvl_d[PIN_SCK];
   assign sck_fall = ~pin_lvl[PIN_SCK] & pin_lvl_d[PIN_SCK];
   assign mosi_bit = pin_lvl[PIN_MOSI];
   assign wp_high = pin_lvl[PIN_WP];

   // Protocol and status state
   sesp_phase_t             phase;
   sesp_phase_t             next_phase;
   logic [7:0]              cmd;
   logic [7:0]              next_cmd;
   logic [7:0]              in_sh;
   logic [7:0]              next_in_sh;
   logic [2:0]              bit_cnt;
   logic [2:0]              next_bit_cnt;
   logic [1:0]              byte_cnt;
   logic [1:0]              next_byte_cnt;
   logic [ADDR_W-1:0]       addr;
   logic [ADDR_W-1:0]       next_addr;
   logic [7:0]              store_data;
   logic [7:0]              next_store_data;
   logic [7:0]              pend;
   logic [7:0]              next_pend;
   logic [CNT_W-1:0]        store_cnt;
   logic [CNT_W-1:0]        next_store_cnt;
   logic                    store_busy;
   logic                    next_store_busy;
   logic                    write_latch_flag;
   logic                    next_write_latch_flag;
   logic                    status_lock_bit;
   logic                    next_status_lock_bit;
   logic [1:0]              protect_size;
   logic [1:0]              next_protect_size;
   logic [7:0]              out_sh;
   logic [7:0]              next_out_sh;
   logic [2:0]              out_cnt;
   logic [2:0]              next_out_cnt;
   logic                    next_miso;
   logic                    next_miso_oe;
   logic                    next_wr_start;
   logic [ADDR_W-1:0]       next_wr_addr;
   logic                    write_busy_flag;
   logic                    pin_locked_mode;
   logic                    addr_guarded;
   logic                    eighth_done;
   logic [7:0]              byte_in;
   logic [7:0]              status_byte;

   assign write_busy_flag = store_busy | mem_busy;
   assign pin_locked_mode = status_lock_bit & ~wp_high;
   assign byte_in = {in_sh[6:0], mosi_bit};
   assign eighth_done = (bit_cnt == BIT_LAST);
   // Layout puts zeros in 6..4 regardless of what was stored
   assign status_byte = {status_lock_bit, 3'h0, protect_size,
                         write_latch_flag, write_busy_flag};

   always_comb begin
      unique case (protect_size)
         PS_NONE:    addr_guarded = 1'b0;
         PS_QUARTER: addr_guarded = (addr >= PROT_QUARTER);
         PS_HALF:    addr_guarded = (addr >= PROT_HALF);
         default:    addr_guarded = 1'b1;
      endcase
   end

   always_comb begin
      next_phase = phase;
      next_cmd = cmd;
      next_in_sh = in_sh;
      next_bit_cnt = bit_cnt;
      next_byte_cnt = byte_cnt;
      next_addr = addr;
      next_store_data = store_data;
      next_pend = pend;
      next_store_cnt = store_cnt;
      next_store_busy = store_busy;
      next_write_latch_flag = write_latch_flag;
      next_status_lock_bit = status_lock_bit;
      next_protect_size = protect_size;
      next_out_sh = out_sh;
      next_out_cnt = out_cnt;
      next_miso = spi_miso;
      next_miso_oe = spi_miso_oe;
      next_wr_start = 1'b0;
      next_wr_addr = mem_write_addr;

      // End of the self-timed store: old protection stays in force until here
      if (store_busy) begin
         next_store_cnt = store_cnt - 1'b1;
         if (store_cnt == {{(CNT_W-1){1'b0}}, 1'b1}) begin
            next_store_busy = 1'b0;
            next_status_lock_bit = pend[SB_LOCK];
            next_protect_size = {pend[SB_PS_HI], pend[SB_PS_LO]};
            next_write_latch_flag = 1'b0;
         end
      end

      if (cs_fall) begin
         next_phase = PH_OPC;
         next_bit_cnt = 3'h0;
         next_byte_cnt = 2'h0;
         next_out_cnt = 3'h0;
      end else if (cs_rise) begin
         next_phase = PH_DESEL;
         next_miso_oe = 1'b0;
         // Select must rise between the eighth bit's rise and the next rise
         if (phase == PH_BODY && bit_cnt == 3'h0) begin
            unique case (cmd)
               OP_ARM: begin
                  if (byte_cnt == 2'h0) begin
                     next_write_latch_flag = 1'b1;
                  end
               end
               OP_DISARM: begin
                  if (byte_cnt == 2'h0) begin
                     next_write_latch_flag = 1'b0;
                  end
               end
               OP_STORE: begin
                  // Refused without latch, while busy, or in pin-locked mode
                  if (byte_cnt != 2'h0 && write_latch_flag && !write_busy_flag
                      && !pin_locked_mode) begin
                     next_pend = store_data;
                     next_store_cnt = CNT_W'(STORE_CYCLES);
                     next_store_busy = 1'b1;
                  end
               end
               OP_WRITE: begin
                  if (byte_cnt == 2'h3 && write_latch_flag && !write_busy_flag
                      && !addr_guarded) begin
                     next_wr_start = 1'b1;
                     next_wr_addr = addr;
                     next_write_latch_flag = 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
      end else if ((phase == PH_OPC || phase == PH_BODY) && sck_rise) begin
         next_in_sh = byte_in;
         next_bit_cnt = bit_cnt + 1'b1;
         if (eighth_done && phase == PH_OPC) begin
            next_cmd = byte_in;
            unique case (byte_in)
               OP_ARM, OP_DISARM, OP_FETCH, OP_STORE, OP_WRITE: begin
                  next_phase = PH_BODY;
               end
               OP_READ: begin
                  // Array read is not served while a write cycle runs
                  next_phase = write_busy_flag ? PH_MUTE : PH_BODY;
               end
               default: begin
                  next_phase = PH_MUTE;
               end
            endcase
         end else if (eighth_done) begin
            if (byte_cnt != 2'h3) begin
               next_byte_cnt = byte_cnt + 1'b1;
            end
            if (cmd == OP_STORE && byte_cnt == 2'h0) begin
               next_store_data = byte_in;
            end
            if (cmd == OP_WRITE && byte_cnt < ADDR_BYTES) begin
               next_addr = {addr[4:0], byte_in};
            end
         end
      end else if (phase == PH_BODY && cmd == OP_FETCH && sck_fall) begin
         // Fresh snapshot each byte, so a running busy cycle is visible
         next_miso_oe = 1'b1;
         next_out_cnt = out_cnt + 1'b1;
         if (out_cnt == 3'h0) begin
            next_miso = status_byte[7];
            next_out_sh = {status_byte[6:0], 1'b0};
         end else begin
            next_miso = out_sh[7];
            next_out_sh = {out_sh[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase <= PH_DESEL;
         cmd <= 8'h00;
         in_sh <= 8'h00;
         bit_cnt <= 3'h0;
         byte_cnt <= 2'h0;
         addr <= '0;
         store_data <= 8'h00;
         pend <= 8'h00;
         store_cnt <= '0;
         store_busy <= 1'b0;
         write_latch_flag <= 1'b0;
         status_lock_bit <= SB_LOCK_RST;
         protect_size <= PS_RST;
         out_sh <= 8'h00;
         out_cnt <= 3'h0;
         spi_miso <= 1'b0;
         spi_miso_oe <= 1'b0;
         mem_write_start <= 1'b0;
         mem_write_addr <= '0;
         protection_status_reg <= 8'h00;
      end else begin
         phase <= next_phase;
         cmd <= next_cmd;
         in_sh <= next_in_sh;
         bit_cnt <= next_bit_cnt;
         byte_cnt <= next_byte_cnt;
         addr <= next_addr;
         store_data <= next_store_data;
         pend <= next_pend;
         store_cnt <= next_store_cnt;
         store_busy <= next_store_busy;
         write_latch_flag <= next_write_latch_flag;
         status_lock_bit <= next_status_lock_bit;
         protect_size <= next_protect_size;
         out_sh <= next_out_sh;
         out_cnt <= next_out_cnt;
         spi_miso <= next_miso;
         spi_miso_oe <= next_miso_oe;
         mem_write_start <= next_wr_start;
         mem_write_addr <= next_wr_addr;
         protection_status_reg <= status_byte;
      end
   end
endmodule

/* File: logic/sesp_pkg.sv */
package sesp_pkg;
   localparam int ADDR_W = 13;
   localparam int CNT_W = 20;

   // Serial opcodes
   localparam logic [7:0] OP_ARM = 8'h06;
   localparam logic [7:0] OP_DISARM = 8'h04;
   localparam logic [7:0] OP_FETCH = 8'h05;
   localparam logic [7:0] OP_STORE = 8'h01;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;

   // Status byte fields
   localparam int SB_LOCK = 7;
   localparam int SB_PS_HI = 3;
   localparam int SB_PS_LO = 2;
   localparam int SB_LATCH = 1;
   localparam int SB_BUSY = 0;

   // Lower bounds of the guarded region per protect size
   localparam logic [ADDR_W-1:0] PROT_QUARTER = 13'h1800;
   localparam logic [ADDR_W-1:0] PROT_HALF = 13'h1000;
   localparam logic [1:0] PS_NONE = 2'h0;
   localparam logic [1:0] PS_QUARTER = 2'h1;
   localparam logic [1:0] PS_HALF = 2'h2;

   // Delivery state of the non-volatile bits
   localparam logic SB_LOCK_RST = 1'h0;
   localparam logic [1:0] PS_RST = 2'h0;

   // Pin vector positions and synchroniser reset
   localparam int PIN_CS = 3;
   localparam int PIN_SCK = 2;
   localparam int PIN_MOSI = 1;
   localparam int PIN_WP = 0;
   localparam logic [3:0] PIN_RST = 4'h0;

   // Self-timed status-store cycle
   localparam int CLK_MHZ = 200;
   localparam int STORE_TIME_NS = 5000000;
   localparam int STORE_CYCLES_DEF = STORE_TIME_NS / 1000 * CLK_MHZ;

   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] ADDR_BYTES = 2'h2;

   typedef enum logic [1:0] {PH_DESEL, PH_OPC, PH_BODY, PH_MUTE} sesp_phase_t;
endpackage
